// ===== verilog/mft_timer.sv
`timescale 1ns/1ps

// Overview of operation
// R01: 16-bit up/down counter behind 8-bit prescaler.
// R02: Two compare and two load/capture registers.
// R03: Per-input rising, falling or both edge selection.
// R04: Compare and overflow apply nop/set/reset/toggle per pin.
// R05: On-chip event from overflow and compare 0.
// R06: Five masked sources into three prioritised requests.
// R07: DMA on capture0 and compare0 pre-empts interrupt.
// R08: Input A or trigger 0 acts on register 0.
// R09: Input B or trigger 1 acts on register 1.
// R10: Input B may trigger register 0 load.
// R11: One-shot stops at end, restarts on trigger.
// R12: Continuous reloads from register 0 or 1.
// R13: Triggered one-shot ignores triggers while counting; a load trigger still restarts the prescaler.
// R14: Retriggered one-shot reloads register 0 on trigger.
// R15: Triggered plus continuous disables all triggers.
// R16: Gated counting advances only while gate low.
// R17: Each register selectable as count capture.
// R18: Software spaces repeated soft captures by one instruction.
// R19: External direction overrides software; status reports direction.
// R20: Free-running wraps without reload in capture modes.
// R21: Autoclear on compare shortens free-run range.
// R22: Clear sets 0000h up, FFFFh down, reloads prescaler.
// R23: Biload alternates reload registers, starting register 0.
// R24: Bicapture alternates capture registers, starting register 0.
// R25: External inputs synchronised before edge detection.
module mft_timer (
  input wire logic ref_clk, // System clock, 10 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire mft_pkg::mft_cfg_s cfg, // Mode configuration.
  input wire mft_pkg::mft_out_cfg_s out_cfg, // Output actions.
  input wire mft_pkg::mft_irq_cfg_s irq_cfg, // Interrupt and DMA masks.
  input wire logic timer_input_a, // External input A.
  input wire logic timer_input_b, // External input B.
  input wire logic soft_trigger_0, // Software trigger 0 pulse.
  input wire logic soft_trigger_1, // Software trigger 1 pulse.
  input wire logic soft_clear, // Software counter clear pulse.
  input wire logic reg0_write, // Write strobe for register 0.
  input wire logic reg1_write, // Write strobe for register 1.
  input wire logic cmp0_write, // Write strobe for compare 0.
  input wire logic cmp1_write, // Write strobe for compare 1.
  input wire logic [15:0] write_data, // Data for the write strobes.
  output logic [15:0] count_value, // Current count.
  output logic [15:0] load_capture_reg_0, // Register 0 contents.
  output logic [15:0] load_capture_reg_1, // Register 1 contents.
  output logic [15:0] compare_reg_0, // Compare 0 contents.
  output logic [15:0] compare_reg_1, // Compare 1 contents.
  output logic count_direction_status, // 1 while counting down.
  output logic running, // Counter is running.
  output logic out_pin_0, // Output pin 0.
  output logic out_pin_1, // Output pin 1.
  output logic on_chip_event, // Pulse to other peripherals.
  output logic irq_eoc, // Request 0: end of count, highest priority.
  output logic irq_capture, // Request 1: captures.
  output logic irq_compare, // Request 2: compares.
  output logic dma_req_cap0, // DMA request, capture into register 0.
  output logic dma_req_cmp0 // DMA request, compare 0 match.
);
  import mft_pkg::*;

  // ==========================================================================
  // Input conditioning
  // ==========================================================================
  logic a_level, a_evt, b_level, b_evt;

  // Both inputs pass through the same synchroniser. [R25] [R03]
  mft_in_sync u_sync_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(timer_input_a),
    .edge_select(cfg.input_a_edge_select),
    .level_out(a_level),
    .event_out(a_evt)
  );

  mft_in_sync u_sync_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(timer_input_b),
    .edge_select(cfg.input_b_edge_select),
    .level_out(b_level),
    .event_out(b_evt)
  );

  // ==========================================================================
  // Input function decode
  // ==========================================================================
  logic a_trig, b_trig, gate_hold, ext_clk, dir_ext, dir_ext_val;
  logic [3:0] ifc;
  assign ifc = cfg.input_function_code;

  // Decode of the pin roles; external direction wins over software. [R16] [R19]
  always_comb begin
    a_trig = 1'b0;
    b_trig = 1'b0;
    gate_hold = 1'b0;
    ext_clk = 1'b0;
    dir_ext = 1'b0;
    dir_ext_val = cfg.soft_count_direction;
    unique case (ifc)
      IFC_NONE: ;
      IFC_B_TRIG: b_trig = b_evt;
      IFC_A_GATE: gate_hold = a_level;
      IFC_A_GATE_B_TRIG: begin
        gate_hold = a_level;
        b_trig = b_evt;
      end
      IFC_B_CLK: ext_clk = b_evt;
      IFC_A_TRIG: a_trig = a_evt;
      IFC_A_GATE_B_CLK: begin
        gate_hold = a_level;
        ext_clk = b_evt;
      end
      IFC_AB_TRIG: begin
        a_trig = a_evt;
        b_trig = b_evt;
      end
      IFC_CLK_UP_DOWN: begin
        ext_clk = a_evt | b_evt;
        dir_ext = a_evt | b_evt; // Between events the last direction holds. [R19]
        dir_ext_val = b_evt & ~a_evt;
      end
      IFC_A_DIR_B_CLK: begin
        ext_clk = b_evt;
        dir_ext = 1'b1;
        dir_ext_val = a_level;
      end
      IFC_TRIG_UP_DOWN: begin
        a_trig = a_evt;
        b_trig = b_evt;
        dir_ext = a_evt | b_evt;
        dir_ext_val = b_evt & ~a_evt;
      end
      IFC_A_DIR: begin
        dir_ext = 1'b1;
        dir_ext_val = a_level;
      end
      IFC_AUTODISCR: begin
        ext_clk = (a_evt & b_level) | (b_evt & a_level);
        dir_ext = ext_clk;
        dir_ext_val = a_evt & b_level;
      end
      IFC_A_TRIG_B_CLK: begin
        a_trig = a_evt;
        ext_clk = b_evt;
      end
      IFC_A_CLK_B_TRIG: begin
        ext_clk = a_evt;
        b_trig = b_evt;
      end
      IFC_A_TRIG_B_GATE: begin
        a_trig = a_evt;
        gate_hold = b_level;
      end
    endcase
  end

  // ==========================================================================
  // Trigger routing
  // ==========================================================================
  logic bicap, biload, free_run, trig_off, trig0, trig1, cap0_evt, cap1_evt, load_evt;
  assign bicap = cfg.bivalue_enable & cfg.reg0_capture_select;
  assign biload = cfg.bivalue_enable & ~cfg.reg0_capture_select;
  // Capture on register 0 in continuous mode means no reload. [R20]
  assign free_run = bicap | (cfg.reg0_capture_select & ~cfg.one_shot_select);
  // Triggered mode with continuous counting masks every trigger. [R15]
  assign trig_off = cfg.retrigger_enable & ~cfg.one_shot_select;
  // Input B joins register 0 when loading with register 1 monitoring. [R08] [R10]
  assign trig0 = ~trig_off & (soft_trigger_0 | a_trig |
                 (~cfg.reg0_capture_select & ~cfg.reg1_capture_select & b_trig));
  // Input B no longer reaches trigger 1 while bivalue mode is on. [R09]
  assign trig1 = ~trig_off & (soft_trigger_1 | (b_trig & ~cfg.bivalue_enable));
  assign cap0_evt = trig0 & cfg.reg0_capture_select; // [R17]
  assign cap1_evt = trig1 & cfg.reg1_capture_select; // [R17]
  assign load_evt = trig0 & ~cfg.reg0_capture_select;

  // ==========================================================================
  // Prescaler and count tick
  // ==========================================================================
  logic [1:0] div3_reg;
  logic [PSC_W-1:0] psc_reg;
  logic tick, clr_now, eoc, cmp0_hit, cmp1_hit, down;
  logic pre_in;
  assign down = dir_ext ? dir_ext_val : (ifc == IFC_CLK_UP_DOWN ? count_direction_status
                                                                 : cfg.soft_count_direction);
  assign pre_in = cfg.external_clock_select ? ext_clk : (div3_reg == PRE_DIV_LAST);

  // Internal clock divided by three feeds the programmable prescaler. [R01]
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div3_reg <= 2'h0;
    end else begin
      div3_reg <= (div3_reg == PRE_DIV_LAST) ? 2'h0 : div3_reg + 2'h1;
    end
  end

  // A clear also restarts the prescaler so the next period is whole. [R22] [R01]
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      psc_reg <= PSC_RST;
    end else if (clr_now || load_evt) begin
      psc_reg <= cfg.prescale_value;
    end else if (pre_in && running && !gate_hold) begin
      psc_reg <= (psc_reg == PSC_RST) ? cfg.prescale_value : psc_reg - 8'h01;
    end
  end

  // Counting pauses while the gate input is high. [R16]
  assign tick = pre_in && running && !gate_hold && (psc_reg == PSC_RST);
  assign eoc = tick && (down ? (count_value == CNT_ZERO) : (count_value == CNT_MAX));
  assign cmp0_hit = tick && (count_value == compare_reg_0);
  assign cmp1_hit = tick && (count_value == compare_reg_1);
  assign clr_now = soft_clear | (cap0_evt & cfg.clear_on_capture) |
                   (cmp0_hit & cfg.clear_on_compare); // [R22] [R21]

  // ==========================================================================
  // Counter and run state
  // ==========================================================================
  logic alt_reg; // Selects register 1 as next reload or capture target.
  logic [15:0] reload_val;
  assign reload_val = (biload && alt_reg && !cfg.one_shot_select) ? load_capture_reg_1
                                                                   : load_capture_reg_0;

  // Counter update, with clear taking precedence over reloads.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_value <= CNT_RST;
    end else if (clr_now) begin
      count_value <= down ? CNT_MAX : CNT_ZERO; // [R22]
    end else if (load_evt && (!cfg.one_shot_select || !running || cfg.retrigger_enable)) begin
      count_value <= load_capture_reg_0; // [R14] [R13]
    end else if (eoc && !free_run && !cfg.one_shot_select) begin
      count_value <= reload_val; // [R12]
    end else if (eoc && cfg.one_shot_select && !free_run) begin
      count_value <= count_value; // [R11]
    end else if (tick) begin
      count_value <= down ? count_value - 16'h0001 : count_value + 16'h0001; // [R01] [R20]
    end
  end

  // Run state: one-shot stops at end of count; any trigger 0 path restarts it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      running <= 1'b1;
    end else if (!cfg.one_shot_select || free_run) begin
      running <= 1'b1;
    end else if (eoc) begin
      running <= 1'b0; // [R11]
    end else if (!running && (trig0 || (b_trig && !trig_off))) begin
      running <= 1'b1; // [R11]
    end
  end

  // Direction status mirrors the active direction. [R19]
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_direction_status <= 1'b0;
    end else begin
      count_direction_status <= down;
    end
  end

  // ==========================================================================
  // Load/capture and compare registers
  // ==========================================================================
  // Alternation pointer: low bivalue forces register 0 as the next target.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alt_reg <= 1'b0;
    end else if (!cfg.bivalue_enable || (biload && load_evt)) begin
      alt_reg <= 1'b0; // [R23]
    end else if ((biload && eoc && !cfg.one_shot_select) || (bicap && trig0)) begin
      alt_reg <= ~alt_reg; // [R23] [R24]
    end
  end

  // Register 0 captures the count, or takes software writes. [R02] [R08]
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      load_capture_reg_0 <= CNT_RST;
    end else if (cap0_evt && !(bicap && alt_reg)) begin
      load_capture_reg_0 <= count_value; // [R24]
    end else if (reg0_write) begin
      load_capture_reg_0 <= write_data;
    end
  end

  // Register 1 captures, monitors the count, or takes writes. [R02] [R09]
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      load_capture_reg_1 <= CNT_RST;
    end else if (bicap && trig0 && alt_reg) begin
      load_capture_reg_1 <= count_value; // [R24]
    end else if (cap1_evt && !cfg.bivalue_enable) begin
      load_capture_reg_1 <= count_value; // [R17]
    end else if (reg1_write) begin
      load_capture_reg_1 <= write_data;
    end else if (!cfg.reg1_capture_select && !cfg.bivalue_enable) begin
      load_capture_reg_1 <= count_value;
    end
  end

  // Compare registers are written by software only. [R02]
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      compare_reg_0 <= CNT_MAX;
      compare_reg_1 <= CNT_MAX;
    end else begin
      if (cmp0_write) compare_reg_0 <= write_data;
      if (cmp1_write) compare_reg_1 <= write_data;
    end
  end

  // ==========================================================================
  // Output pins and on-chip event
  // ==========================================================================
  function automatic logic apply_act(input logic cur, input logic [1:0] act, input logic hit);
    logic res;
    res = cur;
    if (hit) begin
      unique case (act)
        ACT_NOP: res = cur;
        ACT_SET: res = 1'b1;
        ACT_RESET: res = 1'b0;
        ACT_TOGGLE: res = ~cur;
      endcase
    end
    return res;
  endfunction

  // Sources are applied in order overflow, compare 1, compare 0. [R04]
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_pin_0 <= 1'b0;
      out_pin_1 <= 1'b0;
    end else begin
      out_pin_0 <= apply_act(apply_act(apply_act(out_pin_0, out_cfg.ovf_act_0, eoc),
                   out_cfg.cmp1_act_0, cmp1_hit), out_cfg.cmp0_act_0, cmp0_hit);
      out_pin_1 <= apply_act(apply_act(apply_act(out_pin_1, out_cfg.ovf_act_1, eoc),
                   out_cfg.cmp1_act_1, cmp1_hit), out_cfg.cmp0_act_1, cmp0_hit);
    end
  end

  // On-chip event pulses on overflow/underflow or compare 0. [R05]
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      on_chip_event <= 1'b0;
    end else begin
      on_chip_event <= eoc | cmp0_hit;
    end
  end

  // ==========================================================================
  // Interrupt and DMA requests
  // ==========================================================================
  // A DMA-enabled source drives its DMA line instead of its interrupt. [R07] [R06]
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dma_req_cap0 <= 1'b0;
      dma_req_cmp0 <= 1'b0;
      irq_eoc <= 1'b0;
      irq_capture <= 1'b0;
      irq_compare <= 1'b0;
    end else begin
      dma_req_cap0 <= cap0_evt & irq_cfg.dma_cap0_en;
      dma_req_cmp0 <= cmp0_hit & irq_cfg.dma_cmp0_en;
      irq_eoc <= eoc & irq_cfg.eoc_en;
      irq_capture <= (cap0_evt & irq_cfg.cap0_en & ~irq_cfg.dma_cap0_en) |
                     (cap1_evt & irq_cfg.cap1_en);
      irq_compare <= (cmp0_hit & irq_cfg.cmp0_en & ~irq_cfg.dma_cmp0_en) |
                     (cmp1_hit & irq_cfg.cmp1_en);
    end
  end

endmodule // mft_timer

// ===== verilog/mft_pkg.sv
package mft_pkg;

  // ==========================================================================
  // Sizes and reset values
  // ==========================================================================
  localparam int CNT_W = 16;
  localparam int PSC_W = 8;
  localparam int PRE_DIV = 3;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [PSC_W-1:0] PSC_RST = 8'h00;
  localparam logic [1:0] PRE_DIV_LAST = 2'h2;

  // ==========================================================================
  // Input function codes
  // ==========================================================================
  localparam logic [3:0] IFC_NONE = 4'h0;
  localparam logic [3:0] IFC_B_TRIG = 4'h1;
  localparam logic [3:0] IFC_A_GATE = 4'h2;
  localparam logic [3:0] IFC_A_GATE_B_TRIG = 4'h3;
  localparam logic [3:0] IFC_B_CLK = 4'h4;
  localparam logic [3:0] IFC_A_TRIG = 4'h5;
  localparam logic [3:0] IFC_A_GATE_B_CLK = 4'h6;
  localparam logic [3:0] IFC_AB_TRIG = 4'h7;
  localparam logic [3:0] IFC_CLK_UP_DOWN = 4'h8;
  localparam logic [3:0] IFC_A_DIR_B_CLK = 4'h9;
  localparam logic [3:0] IFC_TRIG_UP_DOWN = 4'hA;
  localparam logic [3:0] IFC_A_DIR = 4'hB;
  localparam logic [3:0] IFC_AUTODISCR = 4'hC;
  localparam logic [3:0] IFC_A_TRIG_B_CLK = 4'hD;
  localparam logic [3:0] IFC_A_CLK_B_TRIG = 4'hE;
  localparam logic [3:0] IFC_A_TRIG_B_GATE = 4'hF;

  // ==========================================================================
  // Edge selection and output actions
  // ==========================================================================
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [1:0] ACT_NOP = 2'h0;
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_RESET = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Static configuration, normally held by software.
  typedef struct packed {
    logic one_shot_select;
    logic retrigger_enable;
    logic reg0_capture_select;
    logic reg1_capture_select;
    logic bivalue_enable;
    logic soft_count_direction;
    logic external_clock_select;
    logic clear_on_capture;
    logic clear_on_compare;
    logic [3:0] input_function_code;
    logic [1:0] input_a_edge_select;
    logic [1:0] input_b_edge_select;
    logic [PSC_W-1:0] prescale_value;
  } mft_cfg_s;

  // Per-output action selections: [1:0] per pin for each source.
  typedef struct packed {
    logic [1:0] cmp0_act_0;
    logic [1:0] cmp1_act_0;
    logic [1:0] ovf_act_0;
    logic [1:0] cmp0_act_1;
    logic [1:0] cmp1_act_1;
    logic [1:0] ovf_act_1;
  } mft_out_cfg_s;

  // Interrupt masks: end of count, capture 0/1, compare 0/1, DMA enables.
  typedef struct packed {
    logic eoc_en;
    logic cap0_en;
    logic cap1_en;
    logic cmp0_en;
    logic cmp1_en;
    logic dma_cap0_en;
    logic dma_cmp0_en;
  } mft_irq_cfg_s;

endpackage

// ===== verilog/mft_in_sync.sv
`timescale 1ns/1ps

// ============================================================================
// Input synchroniser and edge detector
// ============================================================================
module mft_in_sync (
  input wire logic ref_clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic pin_in, // Raw external input.
  input wire logic [1:0] edge_select, // Edge sensitivity.
  output logic level_out, // Synchronised level.
  output logic event_out // One-cycle pulse on a selected edge.
);
  import mft_pkg::*;

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // Two flops guard against metastability; only sync_reg and prev_reg are examined.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_out = prev_reg;

  // Edge decode against the selection.
  always_comb begin
    event_out = 1'b0;
    unique case (edge_select)
      EDGE_NONE: event_out = 1'b0;
      EDGE_RISE: event_out = sync_reg & ~prev_reg;
      EDGE_FALL: event_out = ~sync_reg & prev_reg;
      EDGE_BOTH: event_out = sync_reg ^ prev_reg;
    endcase
  end

endmodule // mft_in_sync

// ===== testbench/mft_timer_properties.sv
`timescale 1ns/1ps

// ====
// Port-level checker for the timer
// ====
module mft_timer_properties (
  input wire logic ref_clk, // Clock.
  input wire logic rst, // Reset.
  input wire mft_pkg::mft_cfg_s cfg, // Mode bits.
  input wire mft_pkg::mft_irq_cfg_s irq_cfg, // Masks.
  input wire logic timer_input_a, // Pin A.
  input wire logic soft_clear, // Clear pulse.
  input wire logic cmp0_write, // Strobe.
  input wire logic cmp1_write, // Strobe.
  input wire logic [15:0] write_data, // Data.
  input wire logic [15:0] count_value, // Count.
  input wire logic [15:0] compare_reg_0, // Compare 0.
  input wire logic [15:0] compare_reg_1, // Compare 1.
  input wire logic count_direction_status, // Direction.
  input wire logic on_chip_event, // Event.
  input wire logic irq_eoc, // End of count.
  input wire logic dma_req_cmp0 // DMA.
);
  import mft_pkg::*;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // The clear value depends on the direction in force at the clear.
  a_clear_up_zero: assert property (soft_clear && !count_direction_status |=>
    count_value == CNT_ZERO) else $error("clear up gave wrong count");
  a_clear_down_max: assert property (soft_clear && count_direction_status |=>
    count_value == CNT_MAX) else $error("clear down gave wrong count");
  a_cmp0_write_data: assert property (cmp0_write |=>
    compare_reg_0 == $past(write_data)) else $error("compare 0 write lost");
  a_cmp1_write_data: assert property (cmp1_write |=>
    compare_reg_1 == $past(write_data)) else $error("compare 1 write lost");
  a_dir_follows_soft: assert property (cfg.input_function_code == IFC_NONE &&
    $past(cfg.input_function_code) == IFC_NONE && !$past(rst) |->
    count_direction_status == $past(cfg.soft_count_direction))
    else $error("direction status wrong");
  a_eoc_one_cycle: assert property (irq_eoc |=> !irq_eoc)
    else $error("end of count pulse too long");
  a_eoc_with_event: assert property (irq_eoc |-> on_chip_event)
    else $error("no event with end of count");
  a_eoc_masked: assert property (!irq_cfg.eoc_en && !$past(irq_cfg.eoc_en) |-> !irq_eoc)
    else $error("masked end of count raised");
  a_dma_masked: assert property (!$past(irq_cfg.dma_cmp0_en) |-> !dma_req_cmp0)
    else $error("masked DMA request raised");
  a_gate_holds: assert property ((cfg.input_function_code == IFC_A_GATE && timer_input_a) [*5]
    |=> $stable(count_value)) else $error("count moved while gated");
endmodule // mft_timer_properties

bind mft_timer mft_timer_properties i_mft_timer_properties (.ref_clk, .rst, .cfg, .irq_cfg,
  .timer_input_a, .soft_clear, .cmp0_write, .cmp1_write, .write_data, .count_value,
  .compare_reg_0, .compare_reg_1, .count_direction_status, .on_chip_event, .irq_eoc,
  .dma_req_cmp0);

// ===== testbench/mft_ext_src.sv
`timescale 1ns/1ps

// ====
// Off-chip pulse source
// ====
module mft_ext_src (
  input wire logic ref_clk, // Paces the pulse only.
  input wire logic hold, // Line high while set.
  input wire logic fire, // Request one pulse.
  output logic pin // Line into the timer.
);
  logic pulse = 1'b0;

  // Edges land 37 ns off the clock, so the timer must really synchronise them.
  // Six cycles high keeps the rise and fall edges apart for both-edge sensing.
  always @(posedge ref_clk) begin
    if (fire) begin
      #37 pulse = 1'b1;
      repeat (6) @(posedge ref_clk);
      #37 pulse = 1'b0;
    end
  end

  // Between pulses the line follows hold.
  assign pin = hold | pulse;
endmodule // mft_ext_src

// ===== testbench/tb_mft_timer.sv
`timescale 1ns/1ps

// ====
// Self-checking bench for the timer
// ====
module tb_mft_timer;
  import mft_pkg::*;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  mft_cfg_s cfg = '0;
  mft_out_cfg_s ocfg = '0;
  mft_irq_cfg_s icfg = '0;
  logic ha = 1'b0, fa = 1'b0, fb = 1'b0, pa, pb;
  logic st0 = 1'b0, st1 = 1'b0, clr = 1'b0, w0 = 1'b0, w1 = 1'b0, c0w = 1'b0, c1w = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic [15:0] cnt, r0, r1, c0, c1, s;
  logic dir, run, p0, p1, oce, ieoc, icap;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n, k, c;

  mft_timer i_mft_timer (.ref_clk, .rst, .cfg, .out_cfg(ocfg), .irq_cfg(icfg),
    .timer_input_a(pa), .timer_input_b(pb), .soft_trigger_0(st0), .soft_trigger_1(st1),
    .soft_clear(clr), .reg0_write(w0), .reg1_write(w1), .cmp0_write(c0w), .cmp1_write(c1w),
    .write_data(wd), .count_value(cnt), .load_capture_reg_0(r0), .load_capture_reg_1(r1),
    .compare_reg_0(c0), .compare_reg_1(c1), .count_direction_status(dir), .running(run),
    .out_pin_0(p0), .out_pin_1(p1), .on_chip_event(oce), .irq_eoc(ieoc), .irq_capture(icap),
    .irq_compare(), .dma_req_cap0(), .dma_req_cmp0());
  mft_ext_src i_mft_ext_src_a (.ref_clk, .hold(ha), .fire(fa), .pin(pa));
  mft_ext_src i_mft_ext_src_b (.ref_clk, .hold(1'b0), .fire(fb), .pin(pb));

  // Clock, and a cycle ceiling well above the few hundred cycles the tests need.
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic cyc(input int m);
    repeat (m) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A strobe stays up across exactly one sampling edge.
  task automatic pls(ref logic sig);
    sig = 1'b1;
    cyc(1);
    sig = 1'b0;
  endtask

  task automatic wait_eoc;
    cyc(1);
    k = 0;
    while (ieoc !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    if (k == 200) chk(16'h0000, 16'h0001);
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Main sequence; expected counts are written as 16-bit constants.
  initial begin
    k = $urandom(32'h7747397C);
    icfg.eoc_en = 1'b1;
    icfg.cap1_en = 1'b1;
    cyc(3);
    rst = 1'b0;
    chk(c0, CNT_MAX);
    chk(r0, CNT_RST);
    wd = $urandom;
    pls(c0w);
    chk(c0, wd);
    pls(c1w);
    chk(c1, wd);
    $display("reset and writes done");
    n = $urandom_range(3);
    cfg.prescale_value = n[7:0];
    for (int d = 0; d < 2; d++) begin
      cfg.soft_count_direction = d[0];
      cyc(2);
      pls(clr);
      chk(cnt, d ? CNT_MAX : CNT_ZERO);
      s = cnt;
      cyc(3 * (n + 1) * 4);
      chk(cnt - s, d ? 16'hFFFC : 16'h0004);
      chk({15'h0, dir}, {15'h0, d[0]});
    end
    $display("rate and direction done");
    cfg.prescale_value = 8'h00;
    cfg.soft_count_direction = 1'b0;
    cfg.input_function_code = IFC_A_GATE;
    // The clear restarts a prescaler left mid-period by the rate test.
    cyc(1);
    pls(clr);
    for (int g = 0; g < 2; g++) begin
      ha = ~g[0];
      cyc(6);
      s = cnt;
      cyc(12);
      chk(cnt - s, g ? 16'h0004 : 16'h0000);
    end
    cfg.input_function_code = IFC_NONE;
    $display("gate done");
    ocfg.ovf_act_0 = ACT_TOGGLE;
    ocfg.ovf_act_1 = ACT_SET;
    wd = 16'hFFF0;
    pls(w0);
    pls(st0);
    chk(cnt, 16'hFFF0);
    s = {15'h0, p0};
    wait_eoc;
    chk(cnt, 16'hFFF0);
    chk({15'h0, oce}, 16'h0001);
    cyc(1);
    chk({15'h0, p0}, ~s & 16'h0001);
    chk({15'h0, p1}, 16'h0001);
    cfg.bivalue_enable = 1'b1;
    wd = 16'hFFF8;
    pls(w1);
    for (int i = 0; i < 3; i++) begin
      wait_eoc;
      chk(cnt, i[0] ? 16'hFFF8 : 16'hFFF0);
    end
    cfg.bivalue_enable = 1'b0;
    $display("reload done");
    cfg.one_shot_select = 1'b1;
    wait_eoc;
    cyc(6);
    s = cnt;
    chk({15'h0, run}, 16'h0000);
    cyc(6);
    chk(cnt, s);
    pls(st0);
    chk(cnt, 16'hFFF0);
    cyc(6);
    pls(st0);
    chk((cnt === 16'hFFF0) ? 16'h0001 : 16'h0000, 16'h0000);
    cfg.retrigger_enable = 1'b1;
    cyc(2);
    pls(st0);
    chk(cnt, 16'hFFF0);
    cfg.one_shot_select = 1'b0;
    cfg.retrigger_enable = 1'b0;
    $display("one shot done");
    icfg.eoc_en = 1'b0;
    cfg.reg1_capture_select = 1'b1;
    cfg.input_function_code = IFC_B_TRIG;
    for (int i = 0; i < 2; i++) begin
      s = cnt;
      pls(st1);
      chk((r1 === s || r1 === s + 16'h0001) ? 16'h0001 : 16'h0000, 16'h0001);
      cyc(2);
    end
    for (int e = 0; e < 4; e++) begin
      cfg.input_b_edge_select = e[1:0];
      cyc(4);
      c = 0;
      pls(fb);
      repeat (20) begin
        cyc(1);
        if (icap === 1'b1) c++;
      end
      chk(c[15:0], (e == 3) ? 16'h0002 : ((e == 0) ? 16'h0000 : 16'h0001));
    end
    $display("capture done");
    final_report();
  end
endmodule // tb_mft_timer
